// ---- nvac_pkg.sv ----
// Shared constants for the data store access block
package nvac_pkg;
    localparam int         NVAC_DEPTH         = 64;
    localparam int         NVAC_ADDR_W        = 6;
    localparam int         NVAC_DATA_W        = 8;
    localparam logic [7:0] NVAC_CONTROL_OFS   = 8'h40;
    localparam logic [7:0] NVAC_LOCATION_OFS  = 8'h10;
    localparam logic [7:0] NVAC_BYTE_OFS      = 8'h11;
    localparam logic [7:0] NVAC_BANK_OFS      = 8'h12;
    localparam logic [7:0] NVAC_POINTER_OFS   = 8'h13;
    localparam logic [7:0] NVAC_PORT_OFS      = 8'h14;
    localparam logic       NVAC_BANK_ONE      = 1'b1;
    localparam int         NVAC_BIT_STORE_PERMIT = 3;
    localparam int         NVAC_BIT_STORE_STROBE = 2;
    localparam int         NVAC_BIT_FETCH_PERMIT = 1;
    localparam int         NVAC_BIT_FETCH_STROBE = 0;
    localparam logic [7:0] NVAC_RESET_VALUE   = 8'h00;
    localparam int         NVAC_STORE_CYCLES  = 40;
    localparam int         NVAC_FETCH_CYCLES  = 4;
    localparam int         NVAC_TICK_DIV      = 8;
    localparam int         NVAC_SYNC_STAGES   = 3;
endpackage

// ---- nvac_if.sv ----
// Register access channel between processor core and data store block
`timescale 1ns/1ps
`default_nettype none
interface nvac_if;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       store_done_flag;
    logic       irq_ack;
    modport device (input wr_en, rd_en, addr, wdata, irq_ack,
                    output rdata, store_done_flag);
    modport core   (output wr_en, rd_en, addr, wdata, irq_ack,
                    input rdata, store_done_flag);
endinterface
`default_nettype wire

// ---- nvac_device.sv ----
// Data store access block: registers, fetch and store sequencing
//
// Overview of operation
// [R1] Store holds 64 bytes, reached only via registers
// [R2] Location register: six address bits, top reads zero
// [R3] Byte register: eight bits, resets zero
// [R4] Core reaches control through bank one, pointer 40H
// [R5] Bit 3 permits stores; blocked while low
// [R6] Bit 2 starts store if permitted; cleared at end
// [R7] Bit 1 permits fetches; blocked while low
// [R8] Bit 0 starts fetch if permitted; cleared at end
// [R9] Core never raises both strobes together
// [R10] Core ensures slow clock stable before store; the core does not check it
// [R11] Core leaves control alone until store ends
// [R12] Fetch: address, permit, strobe, poll strobe clear
// [R13] Byte register keeps fetched value until next operation
// [R14] Control bits 7..4 read zero; others reset zero
// [R15] Core stores with permit then strobe, irqs masked
// [R16] Store completion sets the store done flag
// [R17] Store timed by independent slow timer
// [R18] Core avoids sleep during pending operations
// [R19] Cycle lengths are parameters; strobes held throughout
`timescale 1ns/1ps
`default_nettype none
module nvac_device
    import nvac_pkg::*;
#(
    parameter int STORE_CYCLES = NVAC_STORE_CYCLES,
    parameter int FETCH_CYCLES = NVAC_FETCH_CYCLES
) (
    input  wire logic   clock_in,     // System clock
    input  wire logic   reset_in,     // Synchronous reset, high
    input  wire logic   slow_tick_in, // Free running store timer, async
    nvac_if.device      bus           // Core register channel
);
    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    // The step counter is sixteen bits wide; longer counts would wrap
    if (STORE_CYCLES < 1 || STORE_CYCLES > 65535) begin : g_store_chk
        $error("nvac_device: store cycle count out of range");
    end
    if (FETCH_CYCLES < 1 || FETCH_CYCLES > 65535) begin : g_fetch_chk
        $error("nvac_device: fetch cycle count out of range");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        NVAC_IDLE  = 3'b001,
        NVAC_FETCH = 3'b010,
        NVAC_STORE = 3'b100
    } nvac_state_type;

    // Block state other than the array in one register, so reset clears it in one place
    typedef struct packed {
        nvac_state_type st;
        logic [5:0]     location;
        logic [7:0]     data;
        logic [3:0]     control;
        logic [15:0]    count;
        logic [2:0]     tick_sync;
        logic           tick_seen;
        logic           done_flag;
        logic [7:0]     rdata;
    } nvac_dev_type;

    nvac_dev_type s_reg;
    nvac_dev_type s_next;
    // No reset on the array: its contents must outlive a reset
    logic [7:0]   mem [0:NVAC_DEPTH-1]; // [R1]

    // ------------------------------------------------------------
    // Register decoding
    // ------------------------------------------------------------
    // Readback of one register; unmapped offsets read zero
    function automatic logic [7:0] reg_view(
        input logic [7:0] offset,
        input logic [5:0] location,
        input logic [7:0] data,
        input logic [3:0] control
    );
        logic [7:0] v;
        case (offset)
            NVAC_LOCATION_OFS: v = {2'b00, location}; // [R2]
            NVAC_BYTE_OFS:     v = data; // [R3]
            NVAC_CONTROL_OFS:  v = {4'h0, control}; // [R14]
            default:           v = 8'h00;
        endcase
        return v;
    endfunction

    // Last counted step of a fetch or store
    function automatic logic count_end(
        input logic [15:0] count,
        input int          cycles
    );
        return count == 16'(cycles - 1);
    endfunction

    // ------------------------------------------------------------
    // Store timer
    // ------------------------------------------------------------
    // Store timer edges count once stages two and three agree
    logic tick_edge;
    logic store_end;
    assign tick_edge = (s_reg.tick_sync[2] == s_reg.tick_sync[1]) &&
                       (s_reg.tick_sync[1] != s_reg.tick_seen); // [R17]
    // Completion decoded once, so the flag and the array write agree
    assign store_end = (s_reg.st == NVAC_STORE) && tick_edge &&
                       count_end(s_reg.count, STORE_CYCLES); // [R16] [R17]

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.tick_sync = {s_reg.tick_sync[1:0], slow_tick_in};
        if (s_reg.tick_sync[2] == s_reg.tick_sync[1]) begin
            s_next.tick_seen = s_reg.tick_sync[1];
        end
        // Ack clears first, so a store ending in the same cycle wins
        if (bus.irq_ack) begin
            s_next.done_flag = 1'b0;
        end
        if (bus.wr_en) begin
            case (bus.addr)
                NVAC_LOCATION_OFS: begin
                    s_next.location = bus.wdata[5:0]; // [R2]
                end
                NVAC_BYTE_OFS: begin
                    s_next.data = bus.wdata; // [R3]
                end
                NVAC_CONTROL_OFS: begin
                    // Permits always writable; strobes only accepted when permitted
                    s_next.control[NVAC_BIT_STORE_PERMIT] = bus.wdata[NVAC_BIT_STORE_PERMIT]; // [R5]
                    s_next.control[NVAC_BIT_FETCH_PERMIT] = bus.wdata[NVAC_BIT_FETCH_PERMIT]; // [R7]
                    // Permit comes from the register: arming in the same write is refused
                    if (s_reg.st == NVAC_IDLE) begin
                        if (bus.wdata[NVAC_BIT_STORE_STROBE] &&
                            s_reg.control[NVAC_BIT_STORE_PERMIT]) begin
                            s_next.control[NVAC_BIT_STORE_STROBE] = 1'b1; // [R6]
                            s_next.st    = NVAC_STORE;
                            s_next.count = 16'h0000;
                        end else if (bus.wdata[NVAC_BIT_FETCH_STROBE] &&
                                     s_reg.control[NVAC_BIT_FETCH_PERMIT]) begin
                            s_next.control[NVAC_BIT_FETCH_STROBE] = 1'b1; // [R8]
                            s_next.st    = NVAC_FETCH;
                            s_next.count = 16'h0000;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        case (s_reg.st)
            NVAC_FETCH: begin
                // Fetch length counts system clocks; store length counts timer steps
                s_next.count = s_reg.count + 16'h0001; // [R19]
                // Data and strobe clear land together, so a poll never sees stale data
                if (count_end(s_reg.count, FETCH_CYCLES)) begin
                    s_next.data = mem[s_reg.location]; // [R12] [R13]
                    s_next.control[NVAC_BIT_FETCH_STROBE] = 1'b0; // [R8]
                    s_next.st = NVAC_IDLE;
                end
            end
            NVAC_STORE: begin
                if (tick_edge) begin
                    s_next.count = s_reg.count + 16'h0001; // [R17] [R19]
                end
                if (store_end) begin
                    s_next.control[NVAC_BIT_STORE_STROBE] = 1'b0; // [R6]
                    s_next.done_flag = 1'b1; // [R16]
                    s_next.st = NVAC_IDLE;
                end
            end
            default: begin
            end
        endcase
        // Read data shows the value the register holds after this edge
        if (bus.rd_en) begin
            s_next.rdata = reg_view(bus.addr, s_next.location, s_next.data, s_next.control);
        end else begin
            s_next.rdata = 8'h00;
        end
        if (reset_in) begin
            s_next = '0;
            s_next.st = NVAC_IDLE; // [R14]
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        s_reg <= s_next;
        if (!reset_in && store_end) begin
            mem[s_reg.location] <= s_reg.data; // [R1]
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign bus.rdata           = s_reg.rdata;
    assign bus.store_done_flag = s_reg.done_flag;
endmodule
`default_nettype wire

// ---- nvac_core.sv ----
// Core side: bank, pointer and command sequencer for the data store
`timescale 1ns/1ps
`default_nettype none
module nvac_core
    import nvac_pkg::*;
(
    input  wire logic       clock_in,     // System clock
    input  wire logic       reset_in,     // Synchronous reset, high
    input  wire logic       start_in,     // Pulse: begin operation
    input  wire logic       store_in,     // 1 store, 0 fetch
    input  wire logic [5:0] location_in,  // Target location
    input  wire logic [7:0] data_in,      // Byte to store
    output logic            busy_out,     // Operation in progress
    output logic            done_out,     // Pulse: operation finished
    output logic [7:0]      data_out,     // Fetched byte
    output logic            irq_mask_out, // Global irq enable
    nvac_if.core            bus           // Register channel
);
    typedef enum logic [8:0] {
        NC_IDLE   = 9'h001, NC_LOC  = 9'h002, NC_BYTE  = 9'h004,
        NC_BANK   = 9'h008, NC_PTR  = 9'h010, NC_PERM  = 9'h020,
        NC_STROBE = 9'h040, NC_POLL = 9'h080, NC_FIN   = 9'h100
    } nvac_core_state_type;

    typedef struct packed {
        nvac_core_state_type st;
        logic                store;
        logic [5:0]          loc;
        logic [7:0]          data;
        logic                wr_en;
        logic                rd_en;
        logic [7:0]          addr;
        logic [7:0]          wdata;
        logic                busy;
        logic                done;
        logic [7:0]          dout;
        logic                irq_en;
        logic                bank;
        logic                poll_wait;
    } nvac_core_type;

    nvac_core_type c_reg;
    nvac_core_type c_next;
    logic [7:0]    perm;

    always_comb begin
        c_next = c_reg;
        c_next.wr_en = 1'b0;
        c_next.rd_en = 1'b0;
        c_next.done  = 1'b0;
        perm = c_reg.store ? 8'(1 << NVAC_BIT_STORE_PERMIT) : 8'(1 << NVAC_BIT_FETCH_PERMIT);
        case (c_reg.st)
            NC_IDLE: if (start_in) begin
                c_next = '{st: NC_LOC, store: store_in, loc: location_in, data: data_in,
                           wr_en: 1'b1, rd_en: 1'b0, addr: NVAC_LOCATION_OFS,
                           wdata: {2'b00, location_in}, busy: 1'b1, done: 1'b0,
                           dout: c_reg.dout, irq_en: c_reg.irq_en, bank: c_reg.bank,
                           poll_wait: 1'b0};
            end
            NC_LOC: begin
                c_next.st = NC_BYTE;
                if (c_reg.store) begin
                    c_next.wr_en = 1'b1;
                    c_next.addr  = NVAC_BYTE_OFS;
                    c_next.wdata = c_reg.data; // [R15]
                end
            end
            NC_BYTE: begin
                c_next.st = NC_BANK;
                c_next.bank = NVAC_BANK_ONE; // [R4]
            end
            NC_BANK: begin
                // Bank one plus pointer 40H select the control register
                c_next.st = NC_PTR; // [R4]
                c_next.irq_en = c_reg.store ? 1'b0 : c_reg.irq_en; // [R15]
            end
            NC_PTR: begin
                c_next.st = NC_PERM;
                c_next.wr_en = 1'b1;
                c_next.addr  = NVAC_CONTROL_OFS;
                c_next.wdata = perm; // [R9]
            end
            NC_PERM: begin
                // Strobe on the very next cycle, never both strobes
                c_next.st = NC_STROBE;
                c_next.wr_en = 1'b1;
                c_next.addr  = NVAC_CONTROL_OFS;
                c_next.wdata = perm | (c_reg.store ? 8'(1 << NVAC_BIT_STORE_STROBE)
                                                   : 8'(1 << NVAC_BIT_FETCH_STROBE)); // [R9] [R15]
            end
            NC_STROBE: begin
                c_next.st = NC_POLL;
                c_next.irq_en = 1'b1; // [R15]
                c_next.rd_en = 1'b1;
                c_next.addr  = NVAC_CONTROL_OFS;
                c_next.poll_wait = 1'b0;
            end
            NC_POLL: begin
                // Control left untouched until strobe clears
                c_next.rd_en = 1'b1; // [R11] [R12]
                c_next.poll_wait = 1'b1;
                if (c_reg.poll_wait && bus.rdata[c_reg.store ? NVAC_BIT_STORE_STROBE
                                                           : NVAC_BIT_FETCH_STROBE] == 1'b0) begin
                    c_next.st = NC_FIN;
                    c_next.addr = NVAC_BYTE_OFS;
                end
            end
            NC_FIN: begin
                c_next.rd_en = 1'b0;
                if (!c_reg.rd_en) begin
                    c_next.dout = bus.rdata; // [R12]
                    c_next.st = NC_IDLE;
                    c_next.busy = 1'b0;
                    c_next.done = 1'b1;
                    c_next.bank = 1'b0;
                end
            end
            default: c_next.st = NC_IDLE;
        endcase
        if (reset_in) begin
            c_next = '0;
            c_next.st = NC_IDLE;
        end
    end

    always_ff @(posedge clock_in) begin
        c_reg <= c_next;
    end

    assign bus.wr_en   = c_reg.wr_en;
    assign bus.rd_en   = c_reg.rd_en;
    assign bus.addr    = c_reg.addr;
    assign bus.wdata   = c_reg.wdata;
    assign bus.irq_ack = bus.store_done_flag && c_reg.irq_en;
    assign busy_out    = c_reg.busy;
    assign done_out    = c_reg.done;
    assign data_out    = c_reg.dout;
    assign irq_mask_out = c_reg.irq_en;
endmodule
`default_nettype wire

// ---- nvac_assertions.sv ----
// Protocol checker watching the register channel between core and store
`timescale 1ns/1ps
`default_nettype none
module nvac_assertions
    import nvac_pkg::*;
#(
    parameter int FETCH_CYCLES = NVAC_FETCH_CYCLES
) (
    input wire logic       clock_in,        // System clock
    input wire logic       reset_in,        // Synchronous reset, high
    input wire logic       wr_en,           // Register write strobe
    input wire logic       rd_en,           // Register read request
    input wire logic [7:0] addr,            // Register offset
    input wire logic [7:0] wdata,           // Write data
    input wire logic [7:0] rdata,           // Read data
    input wire logic       store_done_flag, // Store done request
    input wire logic       irq_ack          // Flag clear
);
    // ------------------------------------------------------------
    // Helper logic and properties
    // ------------------------------------------------------------
    logic       ctl_wr;
    logic       ctl_rd;
    logic [7:0] fcnt_reg;
    assign ctl_wr = wr_en && (addr == NVAC_CONTROL_OFS);
    assign ctl_rd = rd_en && (addr == NVAC_CONTROL_OFS);

    // Cycles since the last fetch strobe write; saturates
    always_ff @(posedge clock_in) begin
        if (reset_in)
            fcnt_reg <= 8'h00;
        else if (ctl_wr)
            fcnt_reg <= wdata[0] ? 8'h01 : 8'h00;
        else if (fcnt_reg != 8'h00 && fcnt_reg != 8'hFF)
            fcnt_reg <= fcnt_reg + 8'h01;
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);

    property p_ctl_upper;  ctl_rd |=> rdata[7:4] == 4'h0; endproperty
    property p_loc_upper;  rd_en && addr == NVAC_LOCATION_OFS |=> rdata[7:6] == 2'h0; endproperty
    property p_one_strobe; ctl_wr |-> !(wdata[2] && wdata[0]); endproperty
    property p_store_seq;  ctl_wr && wdata[2] |-> $past(ctl_wr) && $past(wdata[3]); endproperty
    property p_fetch_seq;  ctl_wr && wdata[0] |-> $past(ctl_wr) && $past(wdata[1]); endproperty
    property p_flag_hold;  store_done_flag && !irq_ack |=> store_done_flag; endproperty
    property p_ack_flag;   irq_ack |=> !store_done_flag; endproperty
    property p_fetch_busy;
        ctl_rd && fcnt_reg != 8'h00 && int'(fcnt_reg) + 1 <= FETCH_CYCLES |=> rdata[0];
    endproperty
    property p_fetch_clear;
        ctl_rd && int'(fcnt_reg) >= FETCH_CYCLES |=> !rdata[0];
    endproperty

    a_ctl_upper:   assert property (p_ctl_upper)   else $error("control upper bits not zero");
    a_loc_upper:   assert property (p_loc_upper)   else $error("location upper bits not zero");
    a_one_strobe:  assert property (p_one_strobe)  else $error("both strobes written");
    a_store_seq:   assert property (p_store_seq)   else $error("store strobe without permit");
    a_fetch_seq:   assert property (p_fetch_seq)   else $error("fetch strobe without permit");
    a_flag_hold:   assert property (p_flag_hold)   else $error("done flag dropped unacked");
    a_ack_flag:    assert property (p_ack_flag)    else $error("done flag kept after ack");
    a_fetch_busy:  assert property (p_fetch_busy)  else $error("fetch strobe cleared early");
    a_fetch_clear: assert property (p_fetch_clear) else $error("fetch strobe not cleared");

    c_store: cover property (ctl_wr && wdata[2]);
    c_fetch: cover property (ctl_wr && wdata[0]);
    c_done:  cover property ($rose(store_done_flag));
endmodule
`default_nettype wire

// ---- data_eeprom_access_control_bench.sv ----
// Self-checking bench joining core and store ends over the channel
`timescale 1ns/1ps
`default_nettype none
module data_eeprom_access_control_bench;
    import nvac_pkg::*;
    // ------------------------------------------------------------
    // Signals, instances, tasks and scenarios
    // ------------------------------------------------------------
    localparam int STORE_N = 6; // Short store count keeps the run brief
    logic       clock_in, reset_in, slow_tick, start, store, busy, done, irq_mask, flag_q;
    logic [5:0] loc, a;
    logic [7:0] din, dout, d;
    logic [7:0] model [NVAC_DEPTH];
    logic [5:0] addrs [$];
    int         n_fail, total_checks, seed, n_store, n_rise, k;

    nvac_if nvac_if_i ();
    nvac_device #(.STORE_CYCLES(STORE_N), .FETCH_CYCLES(NVAC_FETCH_CYCLES)) nvac_device_i (
        .clock_in(clock_in), .reset_in(reset_in), .slow_tick_in(slow_tick), .bus(nvac_if_i));
    nvac_core nvac_core_i (
        .clock_in(clock_in), .reset_in(reset_in), .start_in(start), .store_in(store),
        .location_in(loc), .data_in(din), .busy_out(busy), .done_out(done),
        .data_out(dout), .irq_mask_out(irq_mask), .bus(nvac_if_i));
    nvac_assertions #(.FETCH_CYCLES(NVAC_FETCH_CYCLES)) nvac_assertions_i (
        .clock_in(clock_in), .reset_in(reset_in), .wr_en(nvac_if_i.wr_en),
        .rd_en(nvac_if_i.rd_en), .addr(nvac_if_i.addr), .wdata(nvac_if_i.wdata),
        .rdata(nvac_if_i.rdata), .store_done_flag(nvac_if_i.store_done_flag),
        .irq_ack(nvac_if_i.irq_ack));

    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end
    // Store timer unrelated in phase to the system clock
    initial begin
        slow_tick = 1'b0;
        forever #37 slow_tick = ~slow_tick;
    end

    always @(posedge clock_in) begin
        if (reset_in) begin
            flag_q <= 1'b0;
        end else begin
            if (nvac_if_i.store_done_flag === 1'b1 && flag_q !== 1'b1)
                n_rise <= n_rise + 1;
            flag_q <= nvac_if_i.store_done_flag;
        end
    end

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_byte(what, {7'h00, exp}, {7'h00, got});
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic run_op(input logic st, input logic [5:0] ad, input logic [7:0] dv);
        int i;
        @(negedge clock_in);
        start = 1'b1;
        store = st;
        loc = ad;
        din = dv;
        @(negedge clock_in);
        start = 1'b0;
        chk_bit("busy_out", 1'b1, busy);
        for (i = 0; i < 2000 && done !== 1'b1; i++) @(negedge clock_in);
        if (i == 2000) begin
            n_fail++;
            $display("[ERR] done_out expected 1 seen timeout");
            results();
        end
        if (st) begin
            model[ad] = dv;
            n_store++;
        end else begin
            chk_byte("data_out", model[ad], dout);
        end
        @(negedge clock_in);
        chk_bit("done_out", 1'b0, done);
        chk_bit("busy_out", 1'b0, busy);
        chk_bit("irq_mask_out", 1'b1, irq_mask);
    endtask

    initial begin
        seed = 32'h77d7;
        {start, store, loc, din, n_fail, total_checks, n_store, n_rise} = '0;
        foreach (model[j]) model[j] = 8'h00;
        reset_in = 1'b1;
        repeat (4) @(negedge clock_in);
        reset_in = 1'b0;
        chk_bit("busy_out", 1'b0, busy);
        chk_byte("data_out", 8'h00, dout);
        // Boundary locations first, then random ones
        for (k = 0; k < 8; k++) begin
            a = (k == 0) ? 6'h00 : (k == 1) ? 6'h3F : 6'($random(seed));
            d = 8'($random(seed));
            run_op(1'b1, a, d);
            addrs.push_back(a);
        end
        run_op(1'b1, 6'h3F, ~model[63]);
        foreach (addrs[j]) run_op(1'b0, addrs[j], 8'h00);
        run_op(1'b0, 6'h3F, 8'h00);
        // Stores and fetches interleaved
        for (k = 0; k < 6; k++) begin
            a = 6'($random(seed));
            run_op(1'b1, a, 8'($random(seed)));
            addrs.push_back(a);
            run_op(1'b0, addrs[k + 2], 8'h00);
        end
        repeat (4) @(negedge clock_in);
        chk_byte("store_done_rises", 8'(n_store), 8'(n_rise));
        // Second reset: contents survive, registers clear
        reset_in = 1'b1;
        repeat (2) @(negedge clock_in);
        reset_in = 1'b0;
        chk_byte("data_out", 8'h00, dout);
        run_op(1'b0, addrs[0], 8'h00);
        results();
    end
endmodule
`default_nettype wire
